// [design/mps_pkg.sv]
// Constants and types for the module power sequencer.
// Notes on behaviour
// R1 - Key low 3 s while off powers up
// R2 - Host waits 30 ms stable supply first
// R3 - Key low 650 ms then release powers down
// R4 - Power-down command behaves like key turn-off
// R5 - Key held low after command restarts module
// R6 - Host cuts supply only after turn-off
// R7 - Key tied low gives automatic power-up
// R8 - Reset low 300 ms then release resets
// R9 - Reset touches baseband only, not power
// R10 - Sleep needs enable, idle wake pins, suspend
// R11 - Host USB data wakes sleeping module
// R12 - Pending report wakes host via USB
// R13 - Without remote wakeup, GPIO wakes host
// R14 - Restored USB supply wakes the module
// R15 - Level 0 disables card and RF
// R16 - Level 1 is full, and default
// R17 - Level 4 disables RF, rejects RF commands
// R18 - Shutdown: software off, rails still connected
// R19 - Key pulses shorter than minimum ignored
package mps_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned ON_MS = 3000;
  localparam int unsigned OFF_MS = 650;
  localparam int unsigned RST_MS = 300;
  localparam int unsigned DOWN_MS = 100;
  localparam int unsigned ON_CYC = ON_MS * (CLK_HZ / 1000);
  localparam int unsigned OFF_CYC = OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned RST_CYC = RST_MS * (CLK_HZ / 1000);
  localparam int unsigned DOWN_CYC = DOWN_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 27;
  localparam logic [11:0] PIN_IDLE = 12'hc00; // Synchroniser value after reset: key and reset pins high.
  localparam logic [2:0] FUN_MIN = 3'h0;
  localparam logic [2:0] FUN_FULL = 3'h1;
  localparam logic [2:0] FUN_AIR = 3'h4;
  typedef enum logic [4:0] {
    MPS_OFF = 5'h01,
    MPS_ON = 5'h02,
    MPS_SLEEP = 5'h04,
    MPS_DOWN = 5'h08,
    MPS_REARM = 5'h10
  } mps_state_t;
endpackage

// [design/mps_sequencer.sv]
// Power-state sequencer: key, reset, functionality level and sleep control.
`timescale 1ns/1ps
// Timing parameters count clock cycles, so a bench may shrink them for short runs.
// DOWN_CYC is the length of the shutdown itself, the same for key and command.
module mps_sequencer #(
  parameter int unsigned ON_CYC = mps_pkg::ON_CYC,
  parameter int unsigned OFF_CYC = mps_pkg::OFF_CYC,
  parameter int unsigned RST_CYC = mps_pkg::RST_CYC,
  parameter int unsigned DOWN_CYC = mps_pkg::DOWN_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_power_key_input_n,
  input wire logic i_module_reset_n,
  input wire logic i_power_down_command,
  input wire logic i_fun_set,
  input wire logic [2:0] i_fun_level,
  input wire logic i_rf_cmd,
  input wire logic i_sleep_enable,
  input wire logic i_wake_pins_active,
  input wire logic i_usb_suspend,
  input wire logic i_usb_host_data,
  input wire logic i_host_remote_wakeup,
  input wire logic i_host_suspend_capable,
  input wire logic i_usb_bus_supply_sense,
  input wire logic i_unsolicited_report,
  output logic o_powered,
  output logic o_software_active,
  output logic o_baseband_reset_n,
  output logic o_rails_connected,
  output logic o_sim_enable,
  output logic o_rf_enable,
  output logic o_rf_cmd_reject,
  output logic o_sleeping,
  output logic o_usb_remote_wake,
  output logic o_gpio_host_wake
);

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every pin-sourced input.
  // The host capability straps are pins as well, so they are synchronised too,
  // even though they are expected to change only while no wake request stands.
  localparam int NS = 12;
  logic [NS-1:0] meta_r;
  logic [NS-1:0] sync_r;
  wire [NS-1:0] raw_in = {i_power_key_input_n, i_module_reset_n, i_power_down_command, i_sleep_enable,
    i_wake_pins_active, i_usb_suspend, i_usb_host_data, i_usb_bus_supply_sense, i_unsolicited_report,
    i_rf_cmd, i_host_remote_wakeup, i_host_suspend_capable};

  // Named views of the second stage; no logic ever reads the first stage.
  // A metastable first stage therefore has a full cycle to settle.
  wire key_low = ~sync_r[11];
  wire rst_low = ~sync_r[10];
  wire cmd_down = sync_r[9];
  wire slp_en = sync_r[8];
  wire wake_act = sync_r[7];
  wire usb_susp = sync_r[6];
  wire usb_data = sync_r[5];
  wire vbus = sync_r[4];
  wire report = sync_r[3];
  wire rf_cmd = sync_r[2];
  wire host_rw = sync_r[1];
  wire host_susp_cap = sync_r[0];

  // Idle level of every pin after reset avoids a false key press.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= mps_pkg::PIN_IDLE;
      sync_r <= mps_pkg::PIN_IDLE;
    end else if (i_ce) begin
      meta_r <= raw_in;
      sync_r <= meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Low-duration counters for key and reset pins; saturate at the top.
  // Saturation keeps a key held for minutes from wrapping and looking short.
  logic [mps_pkg::CNT_W-1:0] key_cnt_r;
  logic [mps_pkg::CNT_W-1:0] rst_cnt_r;
  logic [mps_pkg::CNT_W-1:0] tmr_r;
  logic key_low_d_r;
  logic rst_low_d_r;
  wire [mps_pkg::CNT_W-1:0] cnt_max = {mps_pkg::CNT_W{1'b1}};
  // Turn-on fires on the last count so the press length matches the minimum.
  wire key_on_ok = key_cnt_r >= mps_pkg::CNT_W'(ON_CYC - 1); // R1 R19
  wire key_off_ok = key_cnt_r >= mps_pkg::CNT_W'(OFF_CYC); // R3 R19
  wire key_release = key_low_d_r & ~key_low;
  // The reset pin acts on release after a long enough low, just like key turn-off.
  wire rst_fire = rst_low_d_r & ~rst_low & (rst_cnt_r >= mps_pkg::CNT_W'(RST_CYC)); // R8

  // Counters clear when the pin goes high so a short pulse is forgotten.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      key_cnt_r <= '0;
      rst_cnt_r <= '0;
      key_low_d_r <= 1'b0;
      rst_low_d_r <= 1'b0;
    end else if (i_ce) begin
      key_low_d_r <= key_low;
      rst_low_d_r <= rst_low;
      key_cnt_r <= !key_low ? '0 : (key_cnt_r == cnt_max ? key_cnt_r : key_cnt_r + 1'b1); // R19
      rst_cnt_r <= !rst_low ? '0 : (rst_cnt_r == cnt_max ? rst_cnt_r : rst_cnt_r + 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power state machine.
  mps_pkg::mps_state_t state_r;
  mps_pkg::mps_state_t state_nxt;
  logic cmd_d_r;
  wire cmd_rise = cmd_down & ~cmd_d_r;
  wire tmr_done = tmr_r >= mps_pkg::CNT_W'(DOWN_CYC - 1);
  wire sleep_ok = slp_en & ~wake_act & (usb_susp | ~vbus); // R10 R14
  // Host data, or bus supply back while the bus is not suspended, ends sleep.
  // A pending report does not: the module asks the host to resume instead and
  // stays asleep until it does, which also keeps sleep and run from alternating.
  wire wake_evt = usb_data | vbus & ~usb_susp; // R11 R14
  wire turn_off = key_release & key_off_ok | cmd_rise; // R3 R4

  // Key-off and command-off share the same down path and timing.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      mps_pkg::MPS_OFF: if (key_on_ok) state_nxt = mps_pkg::MPS_REARM; // R1 R7
      // Waiting for release keeps the turn-on press from also counting as turn-off.
      mps_pkg::MPS_REARM: if (!key_low) state_nxt = mps_pkg::MPS_ON;
      mps_pkg::MPS_ON: begin
        if (turn_off) state_nxt = mps_pkg::MPS_DOWN;
        else if (sleep_ok && !wake_evt) state_nxt = mps_pkg::MPS_SLEEP; // R10
      end
      mps_pkg::MPS_SLEEP: begin
        if (turn_off) state_nxt = mps_pkg::MPS_DOWN;
        else if (wake_evt || !sleep_ok) state_nxt = mps_pkg::MPS_ON;
      end
      // A key still held low after the down period turns on again from off; its low time counts from the press, not from off.
      mps_pkg::MPS_DOWN: if (tmr_done) state_nxt = mps_pkg::MPS_OFF; // R5
      // An illegal code falls back to off, the one state that is always safe.
      default: state_nxt = mps_pkg::MPS_OFF;
    endcase
  end

  // Power management state survives the baseband reset pin.
  // The down timer runs only in the down state and starts from zero each time.
  // The command edge detector starts low, matching the idle command pin.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= mps_pkg::MPS_OFF;
      tmr_r <= '0;
      cmd_d_r <= 1'b0;
    end else if (i_ce) begin
      state_r <= state_nxt; // R9
      cmd_d_r <= cmd_down;
      tmr_r <= (state_r == mps_pkg::MPS_DOWN && !tmr_done) ? tmr_r + 1'b1 : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Functionality level and baseband reset pulse.
  // Only levels 0, 1 and 4 exist; any other code keeps the level in force, so a
  // corrupted command cannot leave the radio in an undefined mode.
  logic [2:0] fun_r;
  logic bb_rst_r;
  wire powered = state_r != mps_pkg::MPS_OFF;
  wire fun_legal = i_fun_level == mps_pkg::FUN_MIN || i_fun_level == mps_pkg::FUN_FULL ||
    i_fun_level == mps_pkg::FUN_AIR;

  // Level returns to full on every power-up; illegal levels are ignored.
  // The baseband reset is one cycle long; the power state is left alone.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fun_r <= mps_pkg::FUN_FULL; // R16
      bb_rst_r <= 1'b1;
    end else if (i_ce) begin
      if (!powered || rst_fire) fun_r <= mps_pkg::FUN_FULL; // R16
      else if (i_fun_set && fun_legal) fun_r <= i_fun_level; // R15 R17
      bb_rst_r <= rst_fire; // R8 R9
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  wire run = powered && state_r != mps_pkg::MPS_DOWN;
  wire rf_on = run && fun_r == mps_pkg::FUN_FULL; // R15 R17
  wire sim_on = run && fun_r != mps_pkg::FUN_MIN; // R15
  wire rf_reject = rf_cmd && !rf_on; // R17
  wire sw_on = run && !bb_rst_r; // R9 R18

  // Host wake requests stand while asleep, suspended and with a report pending;
  // the host's strap picks the path, and a host with neither support gets none.
  // The request drops by itself once the host resumes and the module wakes.
  wire pend = state_r == mps_pkg::MPS_SLEEP && report && usb_susp;
  wire usb_wake = pend && host_rw; // R12
  wire gpio_wake = pend && !host_rw && host_susp_cap; // R13

  // Outputs are flopped so the pins never glitch on state decode.
  // The rails stay connected in every state; shutdown only stops software.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_powered <= 1'b0;
      o_software_active <= 1'b0;
      o_baseband_reset_n <= 1'b0;
      o_rails_connected <= 1'b1;
      o_sim_enable <= 1'b0;
      o_rf_enable <= 1'b0;
      o_rf_cmd_reject <= 1'b0;
      o_sleeping <= 1'b0;
      o_usb_remote_wake <= 1'b0;
      o_gpio_host_wake <= 1'b0;
    end else if (i_ce) begin
      o_powered <= powered;
      o_software_active <= sw_on; // R18
      o_baseband_reset_n <= sw_on; // R9
      o_rails_connected <= 1'b1; // R18
      o_sim_enable <= sim_on; // R15
      o_rf_enable <= rf_on;
      o_rf_cmd_reject <= rf_reject; // R17
      o_sleeping <= state_r == mps_pkg::MPS_SLEEP; // R10
      o_usb_remote_wake <= usb_wake; // R12
      o_gpio_host_wake <= gpio_wake; // R13
    end
  end

endmodule

// [tb/mps_props.sv]
// Port checker for the power sequencer.
`timescale 1ns/1ps
module mps_props #(parameter int unsigned ON_CYC = 20) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_power_key_input_n,
  input wire logic i_module_reset_n,
  input wire logic i_sleep_enable,
  input wire logic i_wake_pins_active,
  input wire logic i_host_remote_wakeup,
  input wire logic i_host_suspend_capable,
  input wire logic o_powered,
  input wire logic o_software_active,
  input wire logic o_rails_connected,
  input wire logic o_sim_enable,
  input wire logic o_rf_enable,
  input wire logic o_rf_cmd_reject,
  input wire logic o_sleeping,
  input wire logic o_usb_remote_wake,
  input wire logic o_gpio_host_wake
);
  logic [31:0] low_r;
  // Raw key-low run length; the synchroniser only delays, so this bounds what the design counts.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) low_r <= '0;
    else low_r <= i_power_key_input_n ? '0 : low_r + 32'h1;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  AST_KEY_ON: assert property ($rose(o_powered) |-> low_r >= ON_CYC) else $error("early power-up");
  AST_RAILS: assert property (o_rails_connected) else $error("rails dropped");
  AST_SW_PWR: assert property (o_software_active |-> o_powered) else $error("software while off");
  AST_RF_SIM: assert property (o_rf_enable |-> o_sim_enable && o_powered) else $error("rf without card");
  AST_RF_REJ: assert property (o_rf_cmd_reject |-> !o_rf_enable) else $error("reject with rf on");
  AST_WAKE_ONE: assert property (!(o_usb_remote_wake && o_gpio_host_wake)) else $error("two wake paths");
  AST_USB_WAKE: assert property (o_usb_remote_wake |-> i_host_remote_wakeup) else $error("bad usb wake");
  AST_GPIO_WAKE: assert property (o_gpio_host_wake |-> !i_host_remote_wakeup && i_host_suspend_capable)
    else $error("bad gpio wake");
  AST_RST_KEEP: assert property (o_powered && !i_module_reset_n |=> o_powered) else $error("reset cut power");
  AST_SLEEP_PRE: assert property ($rose(o_sleeping) |-> i_sleep_enable && !i_wake_pins_active)
    else $error("sleep too early");
  // Main scenarios are reached.
  cover property ($rose(o_powered));
  cover property ($rose(o_sleeping));
  cover property ($rose(o_gpio_host_wake));
  cover property ($rose(o_rf_cmd_reject));
endmodule
bind mps_sequencer mps_props #(.ON_CYC(ON_CYC)) i_mps_props (.*);

// [tb/mps_host_model.sv]
// Host controller model driving the power key and the baseband reset pin.
`timescale 1ns/1ps
module mps_host_model #(parameter int unsigned SUPPLY_CYC = 30) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  output logic o_power_key_input_n = 1'b1,
  output logic o_module_reset_n = 1'b1
);
  int ready_cnt = 0;
  // Supply settle time; no press before it runs out, and supply is never cut here.
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ready_cnt <= 0;
    end else if (ready_cnt < SUPPLY_CYC) begin
      ready_cnt <= ready_cnt + 1;
    end
  end
  // Key low for n cycles, then released; caller picks n against the minimum.
  task automatic press_key(input int n);
    while (ready_cnt < SUPPLY_CYC) @(posedge i_core_clk);
    o_power_key_input_n <= 1'b0;
    repeat (n) @(posedge i_core_clk);
    o_power_key_input_n <= 1'b1;
  endtask
  // Baseband reset low for n cycles.
  task automatic pulse_reset(input int n);
    o_module_reset_n <= 1'b0;
    repeat (n) @(posedge i_core_clk);
    o_module_reset_n <= 1'b1;
  endtask
  // Key held at a level, as a tie-low or across a command shutdown.
  task automatic hold_key(input logic lvl);
    o_power_key_input_n <= lvl;
  endtask
endmodule

// [tb/tb_mps_sequencer.sv]
// Self-checking bench for the power sequencer.
`timescale 1ns/1ps
module tb_mps_sequencer;
  localparam int unsigned ON = 20, OFF = 10, RST = 8, DWN = 5;
  logic i_core_clk = 0, i_rst_n = 0, i_ce = 1, i_power_down_command = 0, i_fun_set = 0, i_rf_cmd = 0;
  logic i_sleep_enable = 0, i_wake_pins_active = 0, i_usb_suspend = 0, i_usb_host_data = 0;
  logic i_host_remote_wakeup = 1, i_host_suspend_capable = 1, i_usb_bus_supply_sense = 1;
  logic i_unsolicited_report = 0, i_power_key_input_n, i_module_reset_n;
  logic [2:0] i_fun_level = 3'h1, cur = 3'h1;
  logic o_powered, o_software_active, o_baseband_reset_n, o_rails_connected, o_sim_enable, o_rf_enable;
  logic o_rf_cmd_reject, o_sleeping, o_usb_remote_wake, o_gpio_host_wake;
  logic [31:0] rnd = 32'h0039e197;
  int n_fail = 0, check_count = 0, cyc = 0;
  always #20 i_core_clk = ~i_core_clk;
  mps_sequencer #(.ON_CYC(ON), .OFF_CYC(OFF), .RST_CYC(RST), .DOWN_CYC(DWN)) i_mps_sequencer (.*);
  mps_host_model i_mps_host_model (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .o_power_key_input_n(i_power_key_input_n), .o_module_reset_n(i_module_reset_n));
  //////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Illegal levels leave the previous one in force.
  function automatic logic [2:0] next_lvl(input logic [2:0] c, input logic [2:0] l);
    return (l == 3'h0 || l == 3'h1 || l == 3'h4) ? l : c;
  endfunction
  task automatic check(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %b expected %b", $time, got, exp);
    end
  endtask
  // Samples on falling edges so registered outputs have settled.
  task automatic wait_for(ref logic s, input logic v, input int lim);
    do begin @(negedge i_core_clk); lim--; end while (s !== v && lim > 0);
    check(s, v);
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic power_on();
    rnd = lfsr(rnd);
    @(posedge i_core_clk);
    i_mps_host_model.press_key(ON + 6 + rnd[1:0]);
    wait_for(o_powered, 1'b1, 40);
    cur = 3'h1;
    repeat (6) @(negedge i_core_clk);
    check(o_rf_enable, 1'b1);
  endtask
  task automatic set_fun(input logic [2:0] l);
    @(posedge i_core_clk);
    i_fun_level <= l;
    i_fun_set <= 1'b1;
    @(posedge i_core_clk);
    i_fun_set <= 1'b0;
    cur = next_lvl(cur, l);
    repeat (3) @(negedge i_core_clk);
    check(o_sim_enable, cur != 3'h0);
    check(o_rf_enable, cur == 3'h1);
    check(o_rf_cmd_reject, i_rf_cmd && cur != 3'h1);
  endtask
  // One sleep round: wake pin blocks entry, report picks a wake path, host data or supply wakes.
  task automatic sleep_try(input logic rw, input logic sc);
    @(posedge i_core_clk);
    i_host_remote_wakeup <= rw;
    i_host_suspend_capable <= sc;
    i_sleep_enable <= 1'b1;
    i_wake_pins_active <= 1'b1;
    i_usb_suspend <= sc;
    i_usb_bus_supply_sense <= sc;
    repeat (8) @(negedge i_core_clk);
    check(o_sleeping, 1'b0);
    @(posedge i_core_clk);
    i_wake_pins_active <= 1'b0;
    wait_for(o_sleeping, 1'b1, 10);
    @(posedge i_core_clk);
    i_unsolicited_report <= 1'b1;
    repeat (6) @(negedge i_core_clk);
    check(o_usb_remote_wake, rw && sc);
    check(o_gpio_host_wake, !rw && sc);
    check(o_sleeping, 1'b1);
    @(posedge i_core_clk);
    i_unsolicited_report <= 1'b0;
    i_usb_host_data <= sc;
    i_usb_bus_supply_sense <= 1'b1;
    wait_for(o_sleeping, 1'b0, 10);
    @(posedge i_core_clk);
    {i_usb_host_data, i_usb_suspend, i_sleep_enable} <= 3'h0;
  endtask
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    i_mps_host_model.press_key(ON - 6);
    repeat (10) @(negedge i_core_clk);
    check(o_powered, 1'b0);
    power_on();
    set_fun(3'h0);
    set_fun(3'h4);
    @(posedge i_core_clk);
    i_rf_cmd <= 1'b1;
    repeat (4) @(negedge i_core_clk);
    check(o_rf_cmd_reject, 1'b1);
    repeat (5) begin
      rnd = lfsr(rnd);
      set_fun(rnd[2:0]);
    end
    @(posedge i_core_clk);
    i_rf_cmd <= 1'b0;
    set_fun(3'h1);
    @(posedge i_core_clk);
    i_mps_host_model.pulse_reset(RST - 3);
    repeat (6) begin
      @(negedge i_core_clk);
      check(o_baseband_reset_n, 1'b1);
    end
    check(o_software_active, 1'b1);
    @(posedge i_core_clk);
    i_mps_host_model.pulse_reset(RST + 2);
    wait_for(o_baseband_reset_n, 1'b0, 10);
    check(o_powered, 1'b1);
    repeat (6) @(negedge i_core_clk);
    sleep_try(1'b1, 1'b1);
    sleep_try(1'b0, 1'b1);
    sleep_try(1'b0, 1'b0);
    @(posedge i_core_clk);
    i_mps_host_model.press_key(OFF - 4);
    repeat (10) @(negedge i_core_clk);
    check(o_powered, 1'b1);
    @(posedge i_core_clk);
    i_mps_host_model.press_key(OFF + 2 + rnd[1:0]);
    wait_for(o_powered, 1'b0, DWN + 20);
    check(o_rails_connected, 1'b1);
    power_on();
    @(posedge i_core_clk);
    i_mps_host_model.hold_key(1'b0);
    i_power_down_command <= 1'b1;
    @(posedge i_core_clk);
    i_power_down_command <= 1'b0;
    wait_for(o_powered, 1'b0, DWN + 20);
    wait_for(o_powered, 1'b1, ON + 20);
    @(posedge i_core_clk);
    i_mps_host_model.hold_key(1'b1);
    repeat (10) @(posedge i_core_clk);
    report_and_stop();
  end
endmodule
